/* File: rtl/ros_relay_scale.sv */
// Purpose: Analog input 1 conditioning, slave speed scaling and relay output selection
// Assumes: Percent inputs in tenths of a percent, speeds in tenths of a hertz, signed 16-bit
// Notes: Register port reads return data in the cycle after the read strobe
`timescale 1ns/10ps
`include "ros_defs.svh"

// How it works
// - Analog input 1 level is multiplied by the scale setting, up to 2000.0, default 100.0.
// - Fieldbus type 9 gives speed equal to master speed times scale, clamped to limits.
// - Offset setting spans -500.0 to 500.0 percent of full scale, default 0.0.
// - Monitor value equals applied level minus offset, times scale, readable.
// - Relay selector takes 0 to 12, default 1, choosing the relay source.
// - Selected condition at one energises the relay, else relay released.
// - Selector 0 follows the drive running indication.
// - Selector 1 follows powered and no fault.
// - Selector 2 follows output frequency at setpoint.
// - Selector 3 follows the tripped condition.
// - Selector 4 is output frequency above threshold.
// - Selector 5 is motor current above threshold.
// - Selector 6 is output frequency below threshold.
// - Selector 7 is motor current below threshold.
// - Selector 8 is analog input 2 above threshold.
// - Selector 9 follows ready to run with no trip.
// - Selector 10 follows fire mode active.
// - Selector 11 acts as selector 4 but holds the relay during fire mode.
// - Selector 12 follows bit 8 of the fieldbus control word.
// - Threshold setting 0.0 to 200.0, default 100.0, used by selectors 4 to 8.
// - Hysteresis setting 0.0 to 100.0, default 0.0, stops relay chatter.
module ros_relay_scale #(
    parameter int DW = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic signed [15:0] ai1_level,
    input wire logic signed [15:0] ai2_level,
    input wire logic signed [15:0] master_speed,
    input wire logic signed [15:0] min_speed,
    input wire logic signed [15:0] max_speed,
    input wire logic signed [15:0] out_freq,
    input wire logic signed [15:0] motor_current,
    input wire logic signed [15:0] rated_current,
    input wire logic drv_running,
    input wire logic drv_healthy,
    input wire logic drv_at_speed,
    input wire logic drv_tripped,
    input wire logic drv_ready,
    input wire logic fire_mode,
    input wire logic [15:0] bus_ctrl_word,
    output logic signed [15:0] slave_speed,
    output logic slave_mode,
    output logic relay_on
);
    import ros_pkg::*;

    // Refuse widths the datapath cannot serve
    if (DW != 16) begin : g_dw_check
        $error("ros_relay_scale serves a 16-bit datapath only");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Saturate a wide signed value to 16 bits
    function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
        logic signed [47:0] hi;
        logic signed [47:0] lo;
        hi = 48'sh0000_0000_7FFF;
        lo = -48'sh0000_0000_8000;
        if (v > hi) begin
            sat16 = 16'sh7FFF;
        end else if (v < lo) begin
            sat16 = -16'sh8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // Percent-of-reference to absolute units
    function automatic logic signed [31:0] pct_of(input logic [15:0] pct, input logic signed [15:0] ref_v);
        logic signed [31:0] prod;
        prod = $signed({16'h0000, pct}) * 32'(ref_v);
        pct_of = prod / 32'sd1000;
    endfunction

    // Hysteresis comparator: above type sets at threshold, clears below thr-hyst
    function automatic logic hyst_cmp(input logic prev, input logic above, input logic signed [31:0] v,
                                      input logic signed [31:0] thr, input logic signed [31:0] hy);
        if (above) begin
            if (v >= thr) begin
                hyst_cmp = 1'b1;
            end else if (v < thr - hy) begin
                hyst_cmp = 1'b0;
            end else begin
                hyst_cmp = prev;
            end
        end else begin
            if (v < thr) begin
                hyst_cmp = 1'b1;
            end else if (v >= thr + hy) begin
                hyst_cmp = 1'b0;
            end else begin
                hyst_cmp = prev;
            end
        end
    endfunction

    ros_state_t st_ff;
    ros_state_t nxt_st;

    logic signed [31:0] thr_spd;
    logic signed [31:0] hy_spd;
    logic signed [31:0] thr_cur;
    logic signed [31:0] hy_cur;
    logic signed [31:0] thr_ai;
    logic signed [31:0] hy_ai;
    logic signed [47:0] cond_wide;
    logic signed [47:0] spd_wide;
    logic signed [15:0] spd_sat;
    logic sel_cond;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Register writes, conditioning, comparators and relay select
    always_comb begin
        nxt_st = st_ff;
        // Register writes with range limits
        if (reg_wr) begin
            case (reg_addr)
                `ROS_ADR_SCALE: begin
                    nxt_st.scale = (reg_wdata > `ROS_SCALE_MAX) ? `ROS_SCALE_MAX : reg_wdata;
                end
                `ROS_ADR_OFFSET: begin
                    if ($signed(reg_wdata) > $signed(`ROS_OFFSET_MAX)) begin
                        nxt_st.offset = `ROS_OFFSET_MAX;
                    end else if ($signed(reg_wdata) < $signed(`ROS_OFFSET_MIN)) begin
                        nxt_st.offset = `ROS_OFFSET_MIN;
                    end else begin
                        nxt_st.offset = reg_wdata;
                    end
                end
                `ROS_ADR_RLY_SEL: begin
                    if (reg_wdata <= `ROS_RLY_SEL_MAX) begin
                        nxt_st.rly_sel = reg_wdata;
                    end
                end
                `ROS_ADR_THRESH: begin
                    nxt_st.thresh = (reg_wdata > `ROS_THRESH_MAX) ? `ROS_THRESH_MAX : reg_wdata;
                end
                `ROS_ADR_HYST: begin
                    nxt_st.hyst = (reg_wdata > `ROS_HYST_MAX) ? `ROS_HYST_MAX : reg_wdata;
                end
                `ROS_ADR_BUS_TYPE: begin
                    nxt_st.bus_type = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // Slave flag registered from the fieldbus type
        nxt_st.slave = (nxt_st.bus_type == `ROS_BUS_SLAVE);

        // Conditioned input monitor
        cond_wide = 48'(48'(ai1_level) - 48'($signed(st_ff.offset))) * 48'($signed({1'b0, st_ff.scale}));
        nxt_st.cond_mon = sat16(cond_wide / 48'sd1000);

        // Slave speed with limit clamp
        spd_wide = 48'(master_speed) * 48'($signed({1'b0, st_ff.scale}));
        spd_sat = sat16(spd_wide / 48'sd1000);
        if (spd_sat > max_speed) begin
            nxt_st.speed_out = max_speed;
        end else if (spd_sat < min_speed) begin
            nxt_st.speed_out = min_speed;
        end else begin
            nxt_st.speed_out = spd_sat;
        end

        // Threshold references
        thr_spd = pct_of(st_ff.thresh, max_speed);
        hy_spd = pct_of(st_ff.hyst, max_speed);
        thr_cur = pct_of(st_ff.thresh, rated_current);
        hy_cur = pct_of(st_ff.hyst, rated_current);
        thr_ai = 32'($signed({16'h0000, st_ff.thresh}));
        hy_ai = 32'($signed({16'h0000, st_ff.hyst}));

        // Comparators with hysteresis
        nxt_st.spd_hi = hyst_cmp(st_ff.spd_hi, 1'b1, 32'(out_freq), thr_spd, hy_spd);
        nxt_st.cur_hi = hyst_cmp(st_ff.cur_hi, 1'b1, 32'(motor_current), thr_cur, hy_cur);
        nxt_st.spd_lo = hyst_cmp(st_ff.spd_lo, 1'b0, 32'(out_freq), thr_spd, hy_spd);
        nxt_st.cur_lo = hyst_cmp(st_ff.cur_lo, 1'b0, 32'(motor_current), thr_cur, hy_cur);
        nxt_st.ai2_hi = hyst_cmp(st_ff.ai2_hi, 1'b1, 32'(ai2_level), thr_ai, hy_ai);

        // Relay source select
        case (st_ff.rly_sel[3:0])
            ROS_F_RUN: sel_cond = drv_running;
            ROS_F_HEALTHY: sel_cond = drv_healthy;
            ROS_F_AT_SPEED: sel_cond = drv_at_speed;
            ROS_F_TRIPPED: sel_cond = drv_tripped;
            ROS_F_SPD_HI: sel_cond = st_ff.spd_hi;
            ROS_F_CUR_HI: sel_cond = st_ff.cur_hi;
            ROS_F_SPD_LO: sel_cond = st_ff.spd_lo;
            ROS_F_CUR_LO: sel_cond = st_ff.cur_lo;
            ROS_F_AI2_HI: sel_cond = st_ff.ai2_hi;
            ROS_F_READY: sel_cond = drv_ready & ~drv_tripped;
            ROS_F_FIRE: sel_cond = fire_mode;
            ROS_F_SPD_HI_NF: sel_cond = fire_mode ? st_ff.relay : st_ff.spd_hi;
            ROS_F_FIELDBUS: sel_cond = bus_ctrl_word[`ROS_CTRL_RELAY_BIT];
            default: sel_cond = 1'b0;
        endcase
        nxt_st.relay = sel_cond;

        // Read data, valid only the cycle after the strobe
        nxt_st.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `ROS_ADR_SCALE: nxt_st.rdata = st_ff.scale;
                `ROS_ADR_OFFSET: nxt_st.rdata = st_ff.offset;
                `ROS_ADR_RLY_SEL: nxt_st.rdata = st_ff.rly_sel;
                `ROS_ADR_THRESH: nxt_st.rdata = st_ff.thresh;
                `ROS_ADR_HYST: nxt_st.rdata = st_ff.hyst;
                `ROS_ADR_BUS_TYPE: nxt_st.rdata = st_ff.bus_type;
                `ROS_ADR_COND_MON: nxt_st.rdata = st_ff.cond_mon;
                `ROS_ADR_SPEED_MON: nxt_st.rdata = st_ff.speed_out;
                `ROS_ADR_STATUS: nxt_st.rdata = {10'h000, st_ff.relay, st_ff.ai2_hi, st_ff.cur_lo,
                                                 st_ff.spd_lo, st_ff.cur_hi, st_ff.spd_hi};
                default: nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.scale <= `ROS_SCALE_RST;
            st_ff.offset <= `ROS_OFFSET_RST;
            st_ff.rly_sel <= `ROS_RLY_SEL_RST;
            st_ff.thresh <= `ROS_THRESH_RST;
            st_ff.hyst <= `ROS_HYST_RST;
            st_ff.bus_type <= `ROS_BUS_TYPE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = st_ff.rdata;
    assign slave_speed = st_ff.speed_out;
    assign relay_on = st_ff.relay;
    assign slave_mode = st_ff.slave;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Legal selector only
    property p_sel_range;
        @(posedge clk_sys) disable iff (!nrst) st_ff.rly_sel <= `ROS_RLY_SEL_MAX;
    endproperty
    a_sel_range: assert property (p_sel_range) else $error("relay selector out of range");

    // Selector 0 follows running
    property p_run;
        @(posedge clk_sys) disable iff (!nrst)
            (st_ff.rly_sel == 16'h0000) ##1 (st_ff.rly_sel == 16'h0000) |-> relay_on == $past(drv_running);
    endproperty
    a_run: assert property (p_run) else $error("relay not following running");

    // Selector 1 follows healthy
    property p_healthy;
        @(posedge clk_sys) disable iff (!nrst)
            (st_ff.rly_sel == 16'h0001) ##1 (st_ff.rly_sel == 16'h0001)
            |-> relay_on == $past(drv_healthy);
    endproperty
    a_healthy: assert property (p_healthy) else $error("relay not healthy");

    // Selector 3 follows trip
    property p_trip;
        @(posedge clk_sys) disable iff (!nrst)
            (st_ff.rly_sel == 16'h0003) ##1 (st_ff.rly_sel == 16'h0003) |-> relay_on == $past(drv_tripped);
    endproperty
    a_trip: assert property (p_trip) else $error("relay not following trip");

    // Selector 9 needs ready, no trip
    property p_ready;
        @(posedge clk_sys) disable iff (!nrst)
            (st_ff.rly_sel == 16'h0009) ##1 (st_ff.rly_sel == 16'h0009)
            |-> relay_on == ($past(drv_ready) && !$past(drv_tripped));
    endproperty
    a_ready: assert property (p_ready) else $error("relay not ready");

    // Selector 10 follows fire mode
    property p_fire;
        @(posedge clk_sys) disable iff (!nrst)
            (st_ff.rly_sel == 16'h000A) ##1 (st_ff.rly_sel == 16'h000A)
            |-> relay_on == $past(fire_mode);
    endproperty
    a_fire: assert property (p_fire) else $error("relay not fire");

    // Selector 11 frozen in fire
    property p_fire_hold;
        @(posedge clk_sys) disable iff (!nrst)
            (st_ff.rly_sel == 16'h000B) && fire_mode ##1 (st_ff.rly_sel == 16'h000B) |-> $stable(relay_on);
    endproperty
    a_fire_hold: assert property (p_fire_hold) else $error("relay changed in fire mode");

    // Selector 12 follows bus bit
    property p_bus;
        @(posedge clk_sys) disable iff (!nrst)
            (st_ff.rly_sel == 16'h000C) ##1 (st_ff.rly_sel == 16'h000C) |-> relay_on == $past(bus_ctrl_word[8]);
    endproperty
    a_bus: assert property (p_bus) else $error("relay not following bus bit");

    // Speed inside limits
    property p_clamp;
        @(posedge clk_sys) disable iff (!nrst)
            $stable(max_speed) && $stable(min_speed) && (min_speed <= max_speed) |=>
            (slave_speed <= $past(max_speed)) && (slave_speed >= $past(min_speed));
    endproperty
    a_clamp: assert property (p_clamp) else $error("slave speed outside limits");

    // Above flags set at threshold
    property p_spd_set;
        @(posedge clk_sys) disable iff (!nrst) (32'(out_freq) >= thr_spd) |=> st_ff.spd_hi;
    endproperty
    a_spd_set: assert property (p_spd_set) else $error("above flag not set at threshold");

    property p_cur_set;
        @(posedge clk_sys) disable iff (!nrst) (32'(motor_current) >= thr_cur) |=> st_ff.cur_hi;
    endproperty
    a_cur_set: assert property (p_cur_set) else $error("current flag low");

    // Below flag sets under threshold
    property p_spd_lo;
        @(posedge clk_sys) disable iff (!nrst) (32'(out_freq) < thr_spd) |=> st_ff.spd_lo;
    endproperty
    a_spd_lo: assert property (p_spd_lo) else $error("below flag not set under threshold");

    // Above flag clears under the band
    property p_ai2_clr;
        @(posedge clk_sys) disable iff (!nrst) (32'(ai2_level) < thr_ai - hy_ai) |=> !st_ff.ai2_hi;
    endproperty
    a_ai2_clr: assert property (p_ai2_clr) else $error("analog flag high");

    // Settings in range
    property p_thr_max;
        @(posedge clk_sys) disable iff (!nrst) st_ff.thresh <= `ROS_THRESH_MAX && st_ff.hyst <= `ROS_HYST_MAX;
    endproperty
    a_thr_max: assert property (p_thr_max) else $error("threshold or hysteresis out of range");

    // Read data one cycle late
    property p_rd_late;
        @(posedge clk_sys) disable iff (!nrst) reg_rd && reg_addr == `ROS_ADR_RLY_SEL
            |=> reg_rdata == $past(st_ff.rly_sel);
    endproperty
    a_rd_late: assert property (p_rd_late) else $error("read data wrong");

    c_fire: cover property (@(posedge clk_sys) disable iff (!nrst) st_ff.rly_sel == 16'h000B && fire_mode);
    c_slave: cover property (@(posedge clk_sys) disable iff (!nrst) slave_mode && slave_speed == max_speed);
    // Main scenarios
    c_rise: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(relay_on));
    c_hold: cover property (@(posedge clk_sys) disable iff (!nrst)
        st_ff.rly_sel == 16'h0004 && relay_on && 32'(out_freq) < thr_spd);
    c_bus: cover property (@(posedge clk_sys) disable iff (!nrst) st_ff.rly_sel == 16'h000C && relay_on);
endmodule

/* File: inc/ros_defs.svh */
// Purpose: Offsets, reset values and ranges for the relay select and input scaling block
// Assumes: Settings in tenths of a percent, signed 16-bit words
// Notes: Register offsets are word indices on the plain register port
`ifndef ROS_DEFS_SVH
`define ROS_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ROS_ADR_SCALE 4'h0
`define ROS_ADR_OFFSET 4'h1
`define ROS_ADR_RLY_SEL 4'h2
`define ROS_ADR_THRESH 4'h3
`define ROS_ADR_HYST 4'h4
`define ROS_ADR_BUS_TYPE 4'h5
`define ROS_ADR_COND_MON 4'h6
`define ROS_ADR_SPEED_MON 4'h7
`define ROS_ADR_STATUS 4'h8

// ----------------------------------------
// Reset values and ranges, tenths of a percent
// ----------------------------------------
`define ROS_SCALE_RST 16'h03E8
`define ROS_SCALE_MAX 16'h4E20
`define ROS_OFFSET_RST 16'h0000
`define ROS_OFFSET_MAX 16'h1388
`define ROS_OFFSET_MIN 16'hEC78
`define ROS_RLY_SEL_RST 16'h0001
`define ROS_RLY_SEL_MAX 16'h000C
`define ROS_THRESH_RST 16'h03E8
`define ROS_THRESH_MAX 16'h07D0
`define ROS_HYST_RST 16'h0000
`define ROS_HYST_MAX 16'h03E8
`define ROS_BUS_TYPE_RST 16'h0000
`define ROS_BUS_SLAVE 16'h0009
`define ROS_PCT_UNIT 16'h03E8
`define ROS_CTRL_RELAY_BIT 8

`endif

/* File: inc/ros_pkg.sv */
// Purpose: Types for the relay select and input scaling block
// Assumes: Constants come from ros_defs.svh
// Notes: Selector codes follow the relay function numbering
package ros_pkg;

    // Relay function selector codes
    typedef enum logic [3:0] {
        ROS_F_RUN = 4'b0000,
        ROS_F_HEALTHY = 4'b0001,
        ROS_F_AT_SPEED = 4'b0010,
        ROS_F_TRIPPED = 4'b0011,
        ROS_F_SPD_HI = 4'b0100,
        ROS_F_CUR_HI = 4'b0101,
        ROS_F_SPD_LO = 4'b0110,
        ROS_F_CUR_LO = 4'b0111,
        ROS_F_AI2_HI = 4'b1000,
        ROS_F_READY = 4'b1001,
        ROS_F_FIRE = 4'b1010,
        ROS_F_SPD_HI_NF = 4'b1011,
        ROS_F_FIELDBUS = 4'b1100
    } ros_func_t;

    typedef struct packed {
        logic [15:0] scale;
        logic [15:0] offset;
        logic [15:0] rly_sel;
        logic [15:0] thresh;
        logic [15:0] hyst;
        logic [15:0] bus_type;
        logic [15:0] cond_mon;
        logic [15:0] speed_out;
        logic spd_hi;
        logic cur_hi;
        logic spd_lo;
        logic cur_lo;
        logic ai2_hi;
        logic relay;
        logic slave;
        logic [15:0] rdata;
    } ros_state_t;

endpackage

/* File: bench/ros_ref_load.sv */
// Purpose: Analog reference source and relay contact load on the far side of the drive logic
// Assumes: Levels in tenths of a percent, one clock domain
// Notes: Requested levels reach the inputs one clock later, as a settling reference would
`timescale 1ns/10ps
module ros_ref_load (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic signed [15:0] ai1_req,
    input wire logic signed [15:0] ai2_req,
    input wire logic relay_on,
    output logic signed [15:0] ai1_level,
    output logic signed [15:0] ai2_level,
    output logic [7:0] close_cnt
);
    logic relay_d;

    // Reference levels settle a clock late; the load counts contact closures
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ai1_level <= '0;
            ai2_level <= '0;
            relay_d <= 1'b0;
            close_cnt <= '0;
        end else begin
            ai1_level <= ai1_req;
            ai2_level <= ai2_req;
            relay_d <= relay_on;
            if (relay_on && !relay_d) begin
                close_cnt <= close_cnt + 8'h01;
            end
        end
    end
endmodule

/* File: bench/test_ros_relay_scale.sv */
// Purpose: Self-checking bench for the relay select and input scaling block
// Assumes: 20 MHz clock, asynchronous active-low reset, fixed random seed
// Notes: Max speed and rated current are 1000 so relay limits equal the settings
`timescale 1ns/10ps
`include "ros_defs.svh"
module test_ros_relay_scale;
    import ros_pkg::*;
    logic clk_sys, nrst, reg_wr, reg_rd, slave_mode, relay_on, fire_mode;
    logic drv_running, drv_healthy, drv_at_speed, drv_tripped, drv_ready;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, bus_ctrl_word, rd_val;
    logic signed [15:0] ai1_req, ai2_req, ai1_level, ai2_level, master_speed, min_speed, max_speed;
    logic signed [15:0] out_freq, motor_current, rated_current, slave_speed;
    logic [7:0] close_cnt;
    logic [31:0] seed = 32'h9f64_e8de;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [15:0] dflt [6] = '{`ROS_SCALE_RST, `ROS_OFFSET_RST, `ROS_RLY_SEL_RST, `ROS_THRESH_RST,
                              `ROS_HYST_RST, `ROS_BUS_TYPE_RST};
    logic [3:0] wa [7] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h4, 4'h2, 4'h2};
    logic [15:0] wd [7] = '{16'h5000, 16'h1770, 16'he890, 16'h0bb8, 16'h05dc, 16'h000c, 16'h000d};
    logic [15:0] we [7] = '{`ROS_SCALE_MAX, `ROS_OFFSET_MAX, `ROS_OFFSET_MIN, `ROS_THRESH_MAX,
                            `ROS_HYST_MAX, 16'h000c, 16'h000c};
    int dcodes [7] = '{0, 1, 2, 3, 9, 10, 12};
    int up_v [7] = '{0, 499, 500, 450, 400, 399, 450};
    int dn_v [7] = '{1000, 500, 499, 550, 599, 600, 550};
    logic th_e [7] = '{0, 0, 1, 1, 1, 0, 0};
    logic f11 [6] = '{0, 0, 1, 0, 1, 0};
    int v11 [6] = '{0, 600, 0, 0, 600, 600};
    logic e11 [6] = '{0, 1, 1, 0, 0, 1};

    ros_relay_scale dut_u (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ai1_level, .ai2_level, .master_speed, .min_speed, .max_speed, .out_freq, .motor_current,
        .rated_current, .drv_running, .drv_healthy, .drv_at_speed, .drv_tripped, .drv_ready,
        .fire_mode, .bus_ctrl_word, .slave_speed, .slave_mode, .relay_on);
    ros_ref_load ref_u (.clk_sys, .nrst, .ai1_req, .ai2_req, .relay_on, .ai1_level, .ai2_level,
        .close_cnt);

    // ----------------------------------------
    // Clock and run limit
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Cuts a hang short
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Random source and expectations
    // ----------------------------------------
    function automatic logic [31:0] xrand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int rng(int lo, int hi);
        return lo + int'(xrand() % (hi - lo + 1));
    endfunction

    function automatic logic [15:0] sat_scale(int v, int s);
        int p;
        p = v * s / 1000;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        return p[15:0];
    endfunction

    // Clamp to the bench's speed limits of -500 and 1000
    function automatic logic [15:0] lim(int v);
        if (v > 1000) v = 1000;
        if (v < -500) v = -500;
        return v[15:0];
    endfunction

    function automatic logic direct_exp(int code);
        case (code)
            0: return drv_running;
            1: return drv_healthy;
            2: return drv_at_speed;
            3: return drv_tripped;
            9: return drv_ready & ~drv_tripped;
            10: return fire_mode;
            default: return bus_ctrl_word[`ROS_CTRL_RELAY_BIT];
        endcase
    endfunction

    // ----------------------------------------
    // Compares, bus cycles and stimulus
    // ----------------------------------------
    task automatic chk16(logic [15:0] got, logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(logic got, logic exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    task automatic set_v(int m, int v);
        @(posedge clk_sys);
        case (m)
            4, 6, 11: out_freq <= v[15:0];
            5, 7: motor_current <= v[15:0];
            default: ai2_req <= v[15:0];
        endcase
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int sc, of, v, ms;
        logic [31:0] r;
        nrst = 1'b0;
        {reg_wr, reg_rd, drv_running, drv_at_speed, drv_tripped, drv_ready, fire_mode} = '0;
        drv_healthy = 1'b1;
        reg_addr = 4'h0;
        {reg_wdata, bus_ctrl_word, ai1_req, ai2_req, master_speed, out_freq, motor_current} = '0;
        min_speed = 16'hfe0c;
        max_speed = 16'h03e8;
        rated_current = 16'h03e8;
        do_reset();
        settle();
        chk1(relay_on, 1'b1);
        chk1(slave_mode, 1'b0);
        for (int i = 0; i < 6; i++) begin
            rd(i[3:0]);
            chk16(rd_val, dflt[i]);
        end
        rd(4'hf);
        chk16(rd_val, 16'h0000);
        // Out-of-range writes clamp or are ignored
        for (int i = 0; i < 7; i++) begin
            wr(wa[i], wd[i]);
            rd(wa[i]);
            chk16(rd_val, we[i]);
        end
        wr(4'h6, 16'h1234);
        settle();
        rd(4'h6);
        chk16(rd_val, 16'h7fff);
        // Conditioned input with random settings
        for (int i = 0; i < 8; i++) begin
            sc = rng(0, 20000);
            of = rng(-5000, 5000);
            v = rng(-1000, 1000);
            wr(4'h0, sc[15:0]);
            wr(4'h1, of[15:0]);
            @(posedge clk_sys);
            ai1_req <= v[15:0];
            settle();
            rd(4'h6);
            chk16(rd_val, sat_scale(v - of, sc));
        end
        // Slave speed follows master times scale, clamped
        wr(4'h5, `ROS_BUS_SLAVE);
        for (int i = 0; i < 8; i++) begin
            sc = rng(0, 20000);
            ms = rng(-2000, 2000);
            wr(4'h0, sc[15:0]);
            @(posedge clk_sys);
            master_speed <= ms[15:0];
            settle();
            chk1(slave_mode, 1'b1);
            chk16(slave_speed, lim(ms * sc / 1000));
            rd(4'h7);
            chk16(rd_val, lim(ms * sc / 1000));
        end
        wr(4'h5, 16'h0000);
        settle();
        chk1(slave_mode, 1'b0);
        // Status-driven relay sources and the fieldbus control word bit
        foreach (dcodes[k]) begin
            wr(4'h2, dcodes[k][15:0]);
            for (int i = 0; i < 6; i++) begin
                r = xrand();
                @(posedge clk_sys);
                {drv_running, drv_healthy, drv_at_speed, drv_tripped, drv_ready, fire_mode} <= r[5:0];
                bus_ctrl_word <= r[31:16];
                settle();
                chk1(relay_on, direct_exp(dcodes[k]));
            end
        end
        @(posedge clk_sys);
        fire_mode <= 1'b0;
        drv_healthy <= 1'b1;
        // Threshold sources with hysteresis at their edges
        wr(4'h3, 16'h01f4);
        wr(4'h4, 16'h0064);
        for (int m = 4; m <= 8; m++) begin
            wr(4'h2, m[15:0]);
            for (int i = 0; i < 7; i++) begin
                set_v(m, (m == 6 || m == 7) ? dn_v[i] : up_v[i]);
                settle();
                chk1(relay_on, th_e[i]);
                rd(4'h8);
                chk1(rd_val[5], th_e[i]);
            end
        end
        // Speed above limit, frozen while fire mode is active
        wr(4'h2, 16'h000b);
        for (int i = 0; i < 6; i++) begin
            set_v(11, v11[i]);
            fire_mode <= f11[i];
            settle();
            chk1(relay_on, e11[i]);
        end
        // Reset in mid-run restores the selector default
        do_reset();
        rd(4'h2);
        chk16(rd_val, `ROS_RLY_SEL_RST);
        settle();
        chk1(relay_on, drv_healthy);
        chk16({8'h00, close_cnt}, 16'h0001);
        tally_and_finish();
    end
endmodule
